// File: dv/rx_mac_model.sv
/*
 * MAC receive datapath model: hands frame bytes over one per cycle, or one per two cycles when slow.
 * Assumes the bench fills fb before calling send.
 */
`timescale 1ns/100ps
`default_nettype none
module rx_mac_model (
	input wire logic clk_i,
	output logic valid_o,
	output logic [7:0] data_o,
	output logic sof_o,
	output logic eof_o,
	output logic fcs_ok_o
);
	logic [7:0] fb [0:255];

	// Idle lines at time zero
	initial begin
		valid_o = 1'b0;
		data_o = 8'h00;
		sof_o = 1'b0;
		eof_o = 1'b0;
		fcs_ok_o = 1'b0;
	end

	// Bytes start at the first address byte; slow leaves idle gaps
	task automatic send(input int len, input logic ok, input logic slow);
		for (int k = 0; k < len; k++) begin
			@(posedge clk_i);
			valid_o <= 1'b1;
			data_o <= fb[k];
			sof_o <= (k == 0);
			eof_o <= (k == len - 1);
			fcs_ok_o <= (k == len - 1) ? ok : ~ok;
			if (slow) begin
				@(posedge clk_i);
				valid_o <= 1'b0;
				data_o <= ~fb[k];
			end
		end
		@(posedge clk_i);
		valid_o <= 1'b0;
		eof_o <= 1'b0;
		sof_o <= 1'b0;
		data_o <= ~data_o;
	endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
/*
 * Self-checking bench for the remote wake frame detector.
 * Assumes the MAC model and the bound checker from this folder.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import wake_pkg::*;
	localparam logic [47:0] STA = 48'h021122334455;
	logic clk_i, rst_i, cyc, we, d1, ack, nrx, irq, power_event_out;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [15:0] crc_x;
	wire logic v, s, e, ok;
	wire logic [7:0] rd;
	int miscompares, tests_run, n;

	remote_wake_frame_detector i_remote_wake_frame_detector (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .rx_valid_i(v), .rx_data_i(rd), .rx_sof_i(s),
		.rx_eof_i(e), .rx_fcs_ok_i(ok), .station_addr_i(STA),
		.low_power_d1_i(d1), .normal_rx_en_o(nrx), .irq_o(irq),
		.power_event_out_o(power_event_out));
	rx_mac_model i_rx_mac_model (.clk_i(clk_i), .valid_o(v), .data_o(rd),
		.sof_o(s), .eof_o(e), .fcs_ok_o(ok));

	// Clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic stop_test;
		if (miscompares == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One classic Wishbone cycle; result left in q
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
		if (ack !== 1'b1) begin
			miscompares++;
			stop_test();
		end
		q = rdat;
		cyc <= 1'b0;
	endtask

	function automatic logic [15:0] crc_ref(input logic [15:0] c,
		input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		return c;
	endfunction

	// Frame building into the model's buffer
	task automatic add(input logic [7:0] b);
		i_rx_mac_model.fb[n] = b;
		n++;
	endtask
	task automatic add_a(input logic [47:0] a, input int cnt);
		for (int k = 0; k < 6 * cnt; k++) add(a[47 - 8 * (k % 6) -: 8]);
	endtask
	task automatic pat(input logic [47:0] da);
		n = 0;
		add_a(da, 1);
		add_a(48'h0a0b0c0d0e0f, 1);
		for (int k = 12; k < 64; k++) add(8'(k) ^ 8'ha5);
	endtask
	task automatic wk(input logic [47:0] da, input int cnt);
		n = 0;
		add_a(da, 1);
		add_a(48'h0a0b0c0d0e0f, 1);
		add(8'h42);
		add_a(48'hffffffffffff, 1);
		add_a(STA, 5);
		add(8'h00);
		add(8'hff);
		add_a(48'hffffffffffff, 1);
		add_a(STA, cnt);
		add_a(48'h5a5a5a5a5a5a, 1);
	endtask

	// Send the built frame, then judge flags and notification outputs
	task automatic go(input logic good, input logic slow, input logic [31:0] c);
		i_rx_mac_model.send(n, good, slow);
		repeat (6) @(posedge clk_i);
		wb(1'b0, CSR_OFS, 32'h0);
		chk(q, c);
		chk({power_event_out, irq}, {c[9], c[8]} & {2{|c[5:4]}});
		wb(1'b1, CSR_OFS, c | 32'h30);
	endtask

	task automatic t_regs;
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, 8'h04, 32'hffffffff);
		wb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h7fffffff);
		wb(1'b1, START_OFS, 32'h0c0e0c0c);
		wb(1'b0, START_OFS, 32'h0);
		chk(q, 32'h0c0e0c0c);
		wb(1'b1, CRC_LO_OFS, 32'h1234ffff);
		wb(1'b0, CRC_LO_OFS, 32'h0);
		chk(q, 32'h1234ffff);
	endtask

	task automatic t_pattern;
		crc_x = crc_ref(crc_ref(crc_ref(16'h0, 8'h0e ^ 8'ha5), 8'h10 ^ 8'ha5),
			8'h2c ^ 8'ha5);
		wb(1'b1, 8'h04, 32'h0);
		wb(1'b1, 8'h0c, 32'h40000005);
		wb(1'b1, CRC_HI_OFS, {16'h0, crc_x});
		wb(1'b1, CMD_OFS, 32'h00000001);
		wb(1'b1, CSR_OFS, 32'h102);
		repeat (2) @(posedge clk_i);
		chk(nrx, 1'b0);
		pat(STA);
		go(1'b1, 1'b0, 32'h102);
		wb(1'b1, CMD_OFS, 32'h00010001);
		go(1'b1, 1'b1, 32'h112);
		go(1'b0, 1'b0, 32'h102);
		wb(1'b1, CMD_OFS, 32'h00090001);
		go(1'b1, 1'b0, 32'h102);
		pat(48'h01005e000001);
		go(1'b1, 1'b0, 32'h112);
		wb(1'b1, CSR_OFS, 32'h0);
		repeat (2) @(posedge clk_i);
		chk(nrx, 1'b1);
	endtask

	task automatic t_wake;
		wb(1'b1, CSR_OFS, 32'h204);
		repeat (2) @(posedge clk_i);
		chk(nrx, 1'b0);
		wk(48'hffffffffffff, 16);
		go(1'b1, 1'b0, 32'h224);
		wk(48'hffffffffffff, 15);
		go(1'b1, 1'b0, 32'h204);
		wk(48'h01005e000001, 16);
		go(1'b1, 1'b1, 32'h224);
		wk(48'h02aabbccddee, 16);
		go(1'b1, 1'b0, 32'h204);
		wb(1'b1, CSR_OFS, 32'h200);
		repeat (2) @(posedge clk_i);
		chk(nrx, 1'b1);
		wk(STA, 16);
		go(1'b1, 1'b0, 32'h200);
		d1 <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(nrx, 1'b0);
		go(1'b1, 1'b0, 32'h220);
		d1 <= 1'b0;
	endtask

	// Main sequence
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		d1 = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({nrx, irq, power_event_out}, 3'b100);
		t_regs();
		t_pattern();
		t_wake();
		stop_test();
	end
endmodule
`default_nettype wire

// File: dv/wake_sva.sv
/*
 * Port checker for the remote wake frame detector.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module wake_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [wake_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic rx_valid_i,
	input wire logic rx_eof_i,
	input wire logic rx_fcs_ok_i,
	input wire logic low_power_d1_i,
	input wire logic normal_rx_en_o,
	input wire logic irq_o,
	input wire logic power_event_out_o
);
	logic [3:0] eof_age_r;
	logic [3:0] wr_age_r;

	// Cycles since the last good frame end
	always_ff @(posedge clk_i) begin
		if (rst_i || (rx_valid_i && rx_eof_i && rx_fcs_ok_i))
			eof_age_r <= {4{rst_i}};
		else if (eof_age_r != 4'hf)
			eof_age_r <= eof_age_r + 4'h1;
	end

	// Cycles since the last acknowledged register write
	always_ff @(posedge clk_i) begin
		if (rst_i || (wb_ack_o && wb_we_i))
			wr_age_r <= {4{rst_i}};
		else if (wr_age_r != 4'hf)
			wr_age_r <= wr_age_r + 4'h1;
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_one_pulse: assert property (
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
	a_ack_answers_req: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	a_ack_needs_req: assert property (
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_mask_top_zero: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i inside {8'h04, 8'h08, 8'h0c, 8'h10}
		|-> !wb_dat_o[31]) else $error("mask bit 31 not zero");
	a_d1_stops_rx: assert property (
		low_power_d1_i ##1 low_power_d1_i |-> !normal_rx_en_o)
		else $error("reception not suspended in D1");
	a_irq_has_cause: assert property (
		$rose(irq_o) |-> eof_age_r <= 4'h6 || wr_age_r <= 4'h3)
		else $error("irq without frame end or write");
	a_pme_has_cause: assert property (
		$rose(power_event_out_o) |-> eof_age_r <= 4'h6 || wr_age_r <= 4'h3)
		else $error("power event without frame end or write");
	a_notify_clear: assert property (
		$fell(irq_o) || $fell(power_event_out_o) |-> wr_age_r <= 4'h3)
		else $error("notification dropped without a write");
endmodule

bind remote_wake_frame_detector wake_sva i_wake_sva (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .rx_eof_i(rx_eof_i),
	.rx_fcs_ok_i(rx_fcs_ok_i), .low_power_d1_i(low_power_d1_i),
	.normal_rx_en_o(normal_rx_en_o), .irq_o(irq_o),
	.power_event_out_o(power_event_out_o));
`default_nettype wire

// File: logic/remote_wake_frame_detector.sv
/*
 * Remote wake frame detector: pattern filters and wake packet scanner on
 * the MAC receive byte stream, with a Wishbone register file.
 * Assumes the MAC delivers bytes after preamble removal, marks the first
 * and last byte, and reports the FCS result with the last byte.
 */
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
// Contract
// [RULE1] Filter start position selects first CRC byte
// [RULE2] Software keeps start position at twelve or more
// [RULE3] Expected CRC equal to computed CRC means wake
// [RULE4] Wake packet enable suspends normal reception
// [RULE5] Wake packet notifies via interrupt or power event
// [RULE6] Wake packet sets its received status flag
// [RULE7] Clearing wake packet enable resumes reception
// [RULE8] Only own or broadcast destinations are checked; code also accepts multicast destinations
// [RULE9] Search six sync bytes after both addresses
// [RULE10] Sixteen unbroken address copies declare wake packet
// [RULE11] Broken copy run restarts sync search
// [RULE12] Signature accepted at any payload position
// [RULE13] Multicast frames with sixteen copies also accepted
// [RULE14] Low-power state enables both detectors automatically
// [RULE15] Pattern enable suspends reception, match sets flag
// [RULE16] Four independent pattern filters
// [RULE17] Mask bit j includes byte start plus j
// [RULE18] Command bit 0 enables, bit 3 selects multicast
// [RULE19] Standard CRC-16 over masked bytes per frame
// [RULE20] Flags raised only after good frame ends
`timescale 1ns/100ps
`default_nettype none
module remote_wake_frame_detector (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [wake_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_sof_i,
	input wire logic rx_eof_i,
	input wire logic rx_fcs_ok_i,
	input wire logic [47:0] station_addr_i,
	input wire logic low_power_d1_i,
	output logic normal_rx_en_o,
	output logic irq_o,
	output logic power_event_out_o
);
	import wake_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [MASK_W-1:0] table_mask_r [N_FILTERS];
	logic [CMD_W-1:0] table_cmd_r [N_FILTERS];
	logic [7:0] wake_filter_start_position_r [N_FILTERS];
	logic [15:0] wake_filter_expected_crc_r [N_FILTERS];
	logic [15:0] crc_val [N_FILTERS];
	logic pattern_wake_enable_r;
	logic wake_packet_enable_r;
	logic pattern_wake_received_r;
	logic wake_packet_received_r;
	logic notify_irq_r;
	logic notify_pme_r;
	logic [8:0] pos_cnt_r;
	logic dest_own_r;
	logic dest_bcast_r;
	logic dest_mcast_r;
	logic eval_r;
	logic wp_found;
	logic wp_active;
	logic pw_active;
	logic pat_hit;
	logic wp_hit;
	logic bus_req;
	logic wr_fire;
	logic [31:0] rd_nxt;

	rx_byte_if rx_bus ();

	// Merge written bytes under the byte selects
	function automatic logic [31:0] sel_merge(input logic [31:0] old,
		input logic [31:0] wdat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = wdat[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	// Request seen; write lands on the acknowledged edge
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign wr_fire = bus_req & wb_we_i & wb_ack_o;

	// One-cycle acknowledge, answered for every address
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
		end
	end

	// Read data captured with the acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (bus_req & ~wb_ack_o) begin
			wb_dat_o <= rd_nxt;
		end
	end

	// Read decode; unmapped offsets return zero
	always_comb begin
		rd_nxt = 32'h00000000;
		if (wb_adr_i == CSR_OFS) begin
			rd_nxt[CSR_PW_EN] = pattern_wake_enable_r;
			rd_nxt[CSR_WP_EN] = wake_packet_enable_r;
			rd_nxt[CSR_PW_RCV] = pattern_wake_received_r;
			rd_nxt[CSR_WP_RCV] = wake_packet_received_r;
			rd_nxt[CSR_IRQ_SEL] = notify_irq_r;
			rd_nxt[CSR_PME_SEL] = notify_pme_r;
		end
		for (int i = 0; i < N_FILTERS; i++) begin
			if (wb_adr_i == MASK_OFS + 8'(4 * i)) begin
				rd_nxt = {1'b0, table_mask_r[i]};
			end
			if (wb_adr_i == CMD_OFS) begin
				rd_nxt[FIELD_STRIDE*i +: CMD_W] = table_cmd_r[i];
			end
			if (wb_adr_i == START_OFS) begin
				rd_nxt[FIELD_STRIDE*i +: 8] = wake_filter_start_position_r[i];
			end
		end
		if (wb_adr_i == CRC_LO_OFS) begin
			rd_nxt = {wake_filter_expected_crc_r[1],
				wake_filter_expected_crc_r[0]};
		end
		if (wb_adr_i == CRC_HI_OFS) begin
			rd_nxt = {wake_filter_expected_crc_r[3],
				wake_filter_expected_crc_r[2]};
		end
	end

	// ------------------------------------------------------------------
	// Filter table registers
	// ------------------------------------------------------------------
	// Masks, commands, start positions and expected CRCs per filter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < N_FILTERS; i++) begin
				table_mask_r[i] <= MASK_RST;
				table_cmd_r[i] <= CMD_RST;
				wake_filter_start_position_r[i] <= START_RST; // [RULE1]
				wake_filter_expected_crc_r[i] <= CRC_RST; // [RULE3]
			end
		end else if (wr_fire) begin
			for (int i = 0; i < N_FILTERS; i++) begin
				if (wb_adr_i == MASK_OFS + 8'(4 * i)) begin
					table_mask_r[i] <= MASK_W'(sel_merge(
						{1'b0, table_mask_r[i]},
						wb_dat_i, wb_sel_i)); // [RULE17]
				end
				if (wb_adr_i == CMD_OFS && wb_sel_i[i]) begin
					table_cmd_r[i] <= wb_dat_i[FIELD_STRIDE*i +: CMD_W];
				end
				if (wb_adr_i == START_OFS && wb_sel_i[i]) begin
					wake_filter_start_position_r[i] <=
						wb_dat_i[FIELD_STRIDE*i +: 8]; // [RULE1]
				end
			end
			if (wb_adr_i == CRC_LO_OFS) begin
				{wake_filter_expected_crc_r[1], wake_filter_expected_crc_r[0]}
					<= sel_merge({wake_filter_expected_crc_r[1],
					wake_filter_expected_crc_r[0]}, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == CRC_HI_OFS) begin
				{wake_filter_expected_crc_r[3], wake_filter_expected_crc_r[2]}
					<= sel_merge({wake_filter_expected_crc_r[3],
					wake_filter_expected_crc_r[2]}, wb_dat_i, wb_sel_i);
			end
		end
	end

	// ------------------------------------------------------------------
	// Wake control and status register
	// ------------------------------------------------------------------
	// Enables and notification selects
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pattern_wake_enable_r <= 1'b0;
			wake_packet_enable_r <= 1'b0;
			notify_irq_r <= 1'b0;
			notify_pme_r <= 1'b0;
		end else if (wr_fire && wb_adr_i == CSR_OFS) begin
			if (wb_sel_i[0]) begin
				pattern_wake_enable_r <= wb_dat_i[CSR_PW_EN]; // [RULE15]
				wake_packet_enable_r <= wb_dat_i[CSR_WP_EN]; // [RULE4] [RULE7]
			end
			if (wb_sel_i[1]) begin
				notify_irq_r <= wb_dat_i[CSR_IRQ_SEL];
				notify_pme_r <= wb_dat_i[CSR_PME_SEL];
			end
		end
	end

	// Received flags: hardware set wins over write-one-to-clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pattern_wake_received_r <= 1'b0;
			wake_packet_received_r <= 1'b0;
		end else begin
			pattern_wake_received_r <= (eval_r & pw_active & pat_hit) |
				(pattern_wake_received_r & ~(wr_fire && wb_sel_i[0] &&
				wb_adr_i == CSR_OFS && wb_dat_i[CSR_PW_RCV])); // [RULE15]
			wake_packet_received_r <= (eval_r & wp_active & wp_hit) |
				(wake_packet_received_r & ~(wr_fire && wb_sel_i[0] &&
				wb_adr_i == CSR_OFS && wb_dat_i[CSR_WP_RCV])); // [RULE6]
		end
	end

	// ------------------------------------------------------------------
	// Detection modes and outputs
	// ------------------------------------------------------------------
	// Low-power state forces both detectors on
	assign wp_active = wake_packet_enable_r | low_power_d1_i; // [RULE14]
	assign pw_active = pattern_wake_enable_r | low_power_d1_i; // [RULE14]

	// Normal reception held off while any detector runs; notifications
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			normal_rx_en_o <= 1'b1;
			irq_o <= 1'b0;
			power_event_out_o <= 1'b0;
		end else begin
			normal_rx_en_o <= ~(wp_active | pw_active); // [RULE4] [RULE7]
			irq_o <= notify_irq_r &
				(wake_packet_received_r | pattern_wake_received_r); // [RULE5]
			power_event_out_o <= notify_pme_r &
				(wake_packet_received_r | pattern_wake_received_r); // [RULE5]
		end
	end

	// ------------------------------------------------------------------
	// Receive byte staging
	// ------------------------------------------------------------------
	// Register the MAC bytes and tag each with its frame position
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_bus.valid <= 1'b0;
			rx_bus.data <= 8'h00;
			rx_bus.sof <= 1'b0;
			rx_bus.eof <= 1'b0;
			rx_bus.fcs_ok <= 1'b0;
			rx_bus.pos <= 9'h000;
			pos_cnt_r <= 9'h000;
		end else begin
			rx_bus.valid <= rx_valid_i;
			rx_bus.data <= rx_data_i;
			rx_bus.sof <= rx_valid_i & rx_sof_i;
			rx_bus.eof <= rx_valid_i & rx_eof_i;
			rx_bus.fcs_ok <= rx_fcs_ok_i;
			rx_bus.pos <= rx_sof_i ? 9'h000 : pos_cnt_r; // [RULE19]
			if (rx_valid_i) begin
				if (rx_sof_i) begin
					pos_cnt_r <= 9'h001;
				end else if (pos_cnt_r != POS_MAX) begin
					pos_cnt_r <= pos_cnt_r + 9'h001;
				end
			end
		end
	end

	// Destination class from the first six bytes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dest_own_r <= 1'b0;
			dest_bcast_r <= 1'b0;
			dest_mcast_r <= 1'b0;
		end else if (rx_bus.valid && rx_bus.pos < DA_LEN) begin
			if (rx_bus.sof) begin
				dest_own_r <= rx_bus.data == addr_byte(station_addr_i, 3'h0);
				dest_bcast_r <= rx_bus.data == SYNC_BYTE;
				dest_mcast_r <= rx_bus.data[0];
			end else begin
				dest_own_r <= dest_own_r & (rx_bus.data ==
					addr_byte(station_addr_i, rx_bus.pos[2:0]));
				dest_bcast_r <= dest_bcast_r & (rx_bus.data == SYNC_BYTE);
			end
		end
	end

	// Judge one cycle after the last byte, only on a good FCS
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eval_r <= 1'b0;
		end else begin
			eval_r <= rx_bus.valid & rx_bus.eof & rx_bus.fcs_ok; // [RULE20]
		end
	end

	// ------------------------------------------------------------------
	// Detectors
	// ------------------------------------------------------------------
	// Any enabled filter whose address class and CRC both agree
	always_comb begin
		pat_hit = 1'b0;
		for (int i = 0; i < N_FILTERS; i++) begin
			if (table_cmd_r[i][CMD_EN] &&
				(table_cmd_r[i][CMD_MCAST] ? dest_mcast_r :
				dest_own_r) && // [RULE18]
				crc_val[i] == wake_filter_expected_crc_r[i]) begin
				pat_hit = 1'b1; // [RULE3] [RULE16]
			end
		end
	end

	// Wake packet counts for own, broadcast or multicast frames
	assign wp_hit = wp_found &
		(dest_own_r | dest_bcast_r | dest_mcast_r); // [RULE8] [RULE13]

	// One CRC accumulator per filter
	for (genvar g = 0; g < N_FILTERS; g++) begin : g_filter
		wake_crc16 u_crc (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.rx(rx_bus.snk),
			.start_i(wake_filter_start_position_r[g]),
			.mask_i(table_mask_r[g]),
			.crc_o(crc_val[g])
		);
	end

	// Signature scanner
	wake_packet_scan u_scan (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rx(rx_bus.snk),
		.station_addr_i(station_addr_i),
		.found_o(wp_found)
	);
endmodule
`default_nettype wire

// File: logic/wake_crc16.sv
/*
 * Per-filter CRC-16 accumulator over masked frame bytes.
 * Assumes the byte stream carries frame positions starting at zero.
 */
`timescale 1ns/100ps
`default_nettype none
module wake_crc16 (
	input wire logic clk_i,
	input wire logic rst_i,
	rx_byte_if.snk rx,
	input wire logic [7:0] start_i,
	input wire logic [wake_pkg::MASK_W-1:0] mask_i,
	output logic [15:0] crc_o
);
	import wake_pkg::*;

	logic [8:0] rel;
	logic take;

	// Byte lies in the mask window and its mask bit is set
	always_comb begin
		rel = rx.pos - {1'b0, start_i};
		take = (rx.pos >= {1'b0, start_i}) && (rel < 9'(MASK_W)) &&
			mask_i[rel[4:0]]; // [RULE1] [RULE17]
	end

	// Accumulate, restarting at each frame start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crc_o <= CRC_INIT;
		end else if (rx.valid) begin
			if (rx.sof) begin
				crc_o <= take ? crc16_byte(CRC_INIT, rx.data) : CRC_INIT; // [RULE19]
			end else if (take) begin
				crc_o <= crc16_byte(crc_o, rx.data); // [RULE19]
			end
		end
	end
endmodule
`default_nettype wire

// File: logic/wake_packet_scan.sv
/*
 * Scanner for the wake packet signature: a run of sync bytes followed by
 * sixteen unbroken station address copies, anywhere after the headers.
 * Assumes the byte stream carries frame positions starting at zero.
 */
`timescale 1ns/100ps
`default_nettype none
module wake_packet_scan (
	input wire logic clk_i,
	input wire logic rst_i,
	rx_byte_if.snk rx,
	input wire logic [47:0] station_addr_i,
	output logic found_o
);
	import wake_pkg::*;

	scan_state_type state_r;
	logic [2:0] sync_cnt_r;
	logic [2:0] idx_r;
	logic [4:0] copies_r;
	logic [7:0] expect_byte;

	assign expect_byte = addr_byte(station_addr_i, idx_r);

	// Sync search and address copy counting
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= SCAN_SEARCH;
			sync_cnt_r <= 3'h0;
			idx_r <= 3'h0;
			copies_r <= 5'h00;
			found_o <= 1'b0;
		end else if (rx.valid) begin
			if (rx.sof) begin
				state_r <= SCAN_SEARCH;
				sync_cnt_r <= 3'h0;
				idx_r <= 3'h0;
				copies_r <= 5'h00;
				found_o <= 1'b0;
			end else if (rx.pos >= HDR_LEN) begin // [RULE9] [RULE12]
				unique case (state_r)
				SCAN_SEARCH: begin
					if (sync_cnt_r == SYNC_LEN &&
						rx.data == addr_byte(station_addr_i, 3'h0)) begin
						state_r <= SCAN_ADDR; // [RULE9]
						idx_r <= 3'h1;
						copies_r <= 5'h00;
					end else if (rx.data == SYNC_BYTE) begin
						if (sync_cnt_r != SYNC_LEN) begin
							sync_cnt_r <= sync_cnt_r + 3'h1;
						end
					end else begin
						sync_cnt_r <= 3'h0;
					end
				end
				SCAN_ADDR: begin
					if (rx.data == expect_byte) begin
						if (idx_r == ADDR_LAST) begin
							idx_r <= 3'h0;
							if (copies_r == ADDR_COPIES - 5'h01) begin
								found_o <= 1'b1; // [RULE10]
								state_r <= SCAN_SEARCH;
								sync_cnt_r <= 3'h0;
							end else begin
								copies_r <= copies_r + 5'h01;
							end
						end else begin
							idx_r <= idx_r + 3'h1;
						end
					end else begin
						state_r <= SCAN_SEARCH; // [RULE11]
						idx_r <= 3'h0;
						copies_r <= 5'h00;
						sync_cnt_r <= (rx.data == SYNC_BYTE) ? 3'h1 : 3'h0;
					end
				end
				default: begin
					state_r <= SCAN_SEARCH;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: shared/rx_byte_if.sv
/*
 * Registered receive byte stream shared by the detector's submodules.
 * Assumes one driver (the top) and any number of sinks.
 */
`timescale 1ns/100ps
`default_nettype none
interface rx_byte_if;
	logic valid;
	logic [7:0] data;
	logic sof;
	logic eof;
	logic fcs_ok;
	logic [8:0] pos;
	modport src(output valid, data, sof, eof, fcs_ok, pos);
	modport snk(input valid, data, sof, eof, fcs_ok, pos);
endinterface
`default_nettype wire

// File: shared/wake_pkg.sv
/*
 * Constants, types and helper functions for the remote wake frame
 * detector: register offsets, field positions, reset values, scan lengths.
 * Assumes a 32-bit classic Wishbone register bus and byte-wide receive data.
 */
`default_nettype none
package wake_pkg;
	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int N_FILTERS = 4;
	localparam int MASK_W = 31;
	localparam int ADR_W = 8;
	localparam int POS_W = 9;
	localparam logic [8:0] POS_MAX = 9'h1ff;
	localparam logic [8:0] HDR_LEN = 9'h00c;
	localparam logic [8:0] DA_LEN = 9'h006;
	localparam logic [2:0] SYNC_LEN = 3'h6;
	localparam logic [2:0] ADDR_LAST = 3'h5;
	localparam logic [4:0] ADDR_COPIES = 5'h10;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] CSR_OFS = 8'h00;
	localparam logic [7:0] MASK_OFS = 8'h04;
	localparam logic [7:0] CMD_OFS = 8'h14;
	localparam logic [7:0] START_OFS = 8'h18;
	localparam logic [7:0] CRC_LO_OFS = 8'h1c;
	localparam logic [7:0] CRC_HI_OFS = 8'h20;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CSR_PW_EN = 1;
	localparam int CSR_WP_EN = 2;
	localparam int CSR_PW_RCV = 4;
	localparam int CSR_WP_RCV = 5;
	localparam int CSR_IRQ_SEL = 8;
	localparam int CSR_PME_SEL = 9;
	localparam int CMD_EN = 0;
	localparam int CMD_MCAST = 3;
	localparam int CMD_W = 4;
	localparam int FIELD_STRIDE = 8;

	// ------------------------------------------------------------------
	// Reset values and CRC constants
	// ------------------------------------------------------------------
	localparam logic [30:0] MASK_RST = 31'h00000000;
	localparam logic [3:0] CMD_RST = 4'h0;
	localparam logic [7:0] START_RST = 8'h00;
	localparam logic [15:0] CRC_RST = 16'h0000;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [7:0] SYNC_BYTE = 8'hff;

	typedef enum logic [1:0] {
		SCAN_SEARCH = 2'b01,
		SCAN_ADDR = 2'b10
	} scan_state_type;

	// One byte step of the reflected CRC-16
	function automatic logic [15:0] crc16_byte(input logic [15:0] crc,
		input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	// Byte k of the station address in wire order
	function automatic logic [7:0] addr_byte(input logic [47:0] addr,
		input logic [2:0] k);
		return addr[8'(47 - 8 * int'(k)) -: 8];
	endfunction
endpackage
`default_nettype wire
